// *** hdl/lcd_command_decoder.v ***
// Command decoder: sorts host commands and parameter bytes into settings
// Assumes host pins arrive asynchronously; one clock, async low reset
// Behaviour
// - Codes 30/31 select bank zero/one always
// - E0 opens read-modify-write session
// - EE closes read-modify-write session
// - AA takes four bytes; AB one
// - D1 runs, D2 stops oscillator
// - Bank-zero 20 power control, one byte
// - 81 loads contrast; D6/D7 step it
// - 7C/7D select status register reads
// - 25 changes only the upper-byte flag
// - Read with select low returns status
// - 07 initial code takes one byte
// - Bank-one 20/21 load sixteen-byte gray tables
// - Bank-one 22 gray weight, three bytes
// - Bank-one 32 analog setup, three bytes
// - 34 disables, 35 enables dithering
// - CD enters nv control; CC cancels
// - FC writes, FD reads nv memory
// - Strobe mode needs chip select and strobe
// - Enable mode needs chip select overlap
`include "lcd_cmd_map.vh"
`timescale 1ns/1ps
`default_nettype none

module lcd_command_decoder (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_mode_enable,
  input  wire        i_cs_n,
  input  wire        i_wr_n,
  input  wire        i_rd_n,
  input  wire        i_register_select,
  input  wire [15:0] i_data,
  output reg  [7:0]  o_data,
  output reg         o_data_oe,
  output reg         o_bank_one,
  output reg         o_rmw_active,
  output reg         o_osc_run,
  output reg  [7:0]  o_power_ctrl,
  output reg  [5:0]  o_contrast_level,
  output reg  [7:0]  o_contrast_resist,
  output reg  [7:0]  o_scroll_first_line,
  output reg  [31:0] o_area_scroll,
  output reg  [7:0]  o_nv_initial_code,
  output reg  [23:0] o_gray_weight,
  output reg  [23:0] o_analog_setup,
  output reg         o_dither_on,
  output reg         o_nv_control,
  output reg  [7:0]  o_nv_control_arg,
  output reg         o_nv_write_start,
  output reg         o_nv_read_start,
  output reg  [1:0]  o_nv_status_sel,
  output reg         o_gray_write,
  output reg         o_gray_frame,
  output reg  [3:0]  o_gray_index,
  output reg  [7:0]  o_gray_value,
  output reg         o_upper_byte_err
);

  // =====================================================================
  // Parameter target encodings
  localparam [3:0] T_NONE   = 4'h0;
  localparam [3:0] T_ASCR   = 4'h1;
  localparam [3:0] T_SCRL   = 4'h2;
  localparam [3:0] T_PWR    = 4'h3;
  localparam [3:0] T_VOL    = 4'h4;
  localparam [3:0] T_INIT   = 4'h5;
  localparam [3:0] T_GRAY1  = 4'h6;
  localparam [3:0] T_GRAY2  = 4'h7;
  localparam [3:0] T_WGHT   = 4'h8;
  localparam [3:0] T_ANA    = 4'h9;
  localparam [3:0] T_NVCT   = 4'hA;

  wire        wr_pulse;
  wire        rd_active;
  wire        rs;
  wire [15:0] data;
  wire [7:0]  code;
  reg  [3:0]  target_reg;
  reg  [4:0]  remain_reg;
  reg  [4:0]  index_reg;
  reg  [7:0]  status_reg;

  assign code = data[7:0];

  lcd_bus_front u_front (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_mode_enable (i_mode_enable),
    .i_cs_n        (i_cs_n),
    .i_wr_n        (i_wr_n),
    .i_rd_n        (i_rd_n),
    .i_rs          (i_register_select),
    .i_data        (i_data),
    .o_write_pulse (wr_pulse),
    .o_read_active (rd_active),
    .o_rs          (rs),
    .o_data        (data)
  );

  // =====================================================================
  // Code to parameter target, per bank
  function [3:0] target_of;
    input       bank;
    input [7:0] c;
    begin
      target_of = T_NONE;
      if (!bank) begin
        case (c)
          `C0_AREA_SCROLL:   target_of = T_ASCR;
          `C0_SCROLL_LINE:   target_of = T_SCRL;
          `C0_POWER_CTRL:    target_of = T_PWR;
          `C0_CONTRAST_LOAD: target_of = T_VOL;
          `C0_NV_INIT_CODE:  target_of = T_INIT;
          default:           target_of = T_NONE;
        endcase
      end else begin
        case (c)
          `C1_GRAY_FRAME_ONE: target_of = T_GRAY1;
          `C1_GRAY_FRAME_TWO: target_of = T_GRAY2;
          `C1_GRAY_WEIGHT:    target_of = T_WGHT;
          `C1_ANALOG_SETUP:   target_of = T_ANA;
          `C1_NV_CTRL_ENTER:  target_of = T_NVCT;
          default:            target_of = T_NONE;
        endcase
      end
    end
  endfunction

  function [4:0] count_of;
    input [3:0] t;
    begin
      case (t)
        T_ASCR:  count_of = `N_AREA_SCROLL;
        T_SCRL:  count_of = `N_SCROLL_LINE;
        T_PWR:   count_of = `N_POWER_CTRL;
        T_VOL:   count_of = `N_CONTRAST_LOAD;
        T_INIT:  count_of = `N_NV_INIT_CODE;
        T_GRAY1: count_of = `N_GRAY_TABLE;
        T_GRAY2: count_of = `N_GRAY_TABLE;
        T_WGHT:  count_of = `N_GRAY_WEIGHT;
        T_ANA:   count_of = `N_ANALOG_SETUP;
        T_NVCT:  count_of = `N_NV_CTRL_ENTER;
        default: count_of = 5'h00;
      endcase
    end
  endfunction

  // =====================================================================
  // Command and parameter handling
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bank_one          <= 1'b0;
      o_rmw_active        <= 1'b0;
      o_osc_run           <= 1'b0;
      o_power_ctrl        <= `RST_BYTE;
      o_contrast_level    <= `RST_CONTRAST;
      o_contrast_resist   <= `RST_BYTE;
      o_scroll_first_line <= `RST_BYTE;
      o_area_scroll       <= 32'h0000_0000;
      o_nv_initial_code   <= `RST_BYTE;
      o_gray_weight       <= 24'h00_0000;
      o_analog_setup      <= 24'h00_0000;
      o_dither_on         <= 1'b0;
      o_nv_control        <= 1'b0;
      o_nv_control_arg    <= `RST_BYTE;
      o_nv_write_start    <= 1'b0;
      o_nv_read_start     <= 1'b0;
      o_nv_status_sel     <= 2'h0;
      o_gray_write        <= 1'b0;
      o_gray_frame        <= 1'b0;
      o_gray_index        <= 4'h0;
      o_gray_value        <= `RST_BYTE;
      o_upper_byte_err    <= 1'b0;
      target_reg          <= T_NONE;
      remain_reg          <= 5'h00;
      index_reg           <= 5'h00;
    end else begin
      // Start strobes last one cycle only
      o_nv_write_start <= 1'b0;
      o_nv_read_start  <= 1'b0;
      o_gray_write     <= 1'b0;
      if (wr_pulse && !rs) begin
        // A new command abandons any unfinished parameter run
        o_upper_byte_err <= (data[15:8] != 8'h00);
        target_reg <= target_of(o_bank_one, code);
        remain_reg <= count_of(target_of(o_bank_one, code));
        index_reg  <= 5'h00;
        if (code == `BANK_ZERO_SEL)
          o_bank_one <= 1'b0;
        else if (code == `BANK_ONE_SEL)
          o_bank_one <= 1'b1;
        else if (!o_bank_one) begin
          case (code)
            `C0_RMW_BEGIN:     o_rmw_active <= 1'b1;
            `C0_RMW_END:       o_rmw_active <= 1'b0;
            `C0_OSC_RUN:       o_osc_run <= 1'b1;
            `C0_OSC_STOP:      o_osc_run <= 1'b0;
            `C0_CONTRAST_UP: begin
              if (o_contrast_level != `CONTRAST_MAX)
                o_contrast_level <= o_contrast_level + 6'h01;
            end
            `C0_CONTRAST_DOWN: begin
              if (o_contrast_level != 6'h00)
                o_contrast_level <= o_contrast_level - 6'h01;
            end
            `C0_NV_STAT_ONE:   o_nv_status_sel <= 2'h1;
            `C0_NV_STAT_TWO:   o_nv_status_sel <= 2'h2;
            // No-op and reserved code leave every setting but the upper-byte flag alone
            `C0_NOP:           o_nv_status_sel <= o_nv_status_sel;
            default:           o_nv_status_sel <= o_nv_status_sel;
          endcase
        end else begin
          case (code)
            `C1_DITHER_OFF:     o_dither_on <= 1'b0;
            `C1_DITHER_ON:      o_dither_on <= 1'b1;
            `C1_NV_CTRL_CANCEL: o_nv_control <= 1'b0;
            `C1_NV_MEM_WRITE:   o_nv_write_start <= 1'b1;
            `C1_NV_MEM_READ:    o_nv_read_start <= 1'b1;
            default:            o_nv_control <= o_nv_control;
          endcase
        end
      end else if (wr_pulse && rs && remain_reg != 5'h00) begin
        // Surplus parameter bytes fall through unused
        remain_reg <= remain_reg - 5'h01;
        index_reg  <= index_reg + 5'h01;
        case (target_reg)
          T_ASCR: o_area_scroll <= {o_area_scroll[23:0], code};
          T_SCRL: o_scroll_first_line <= code;
          T_PWR:  o_power_ctrl <= code;
          T_VOL: begin
            if (index_reg == 5'h00)
              o_contrast_level <= code[5:0];
            else
              o_contrast_resist <= code;
          end
          T_INIT: o_nv_initial_code <= code;
          T_GRAY1, T_GRAY2: begin
            o_gray_write <= 1'b1;
            o_gray_frame <= (target_reg == T_GRAY2);
            o_gray_index <= index_reg[3:0];
            o_gray_value <= code;
          end
          T_WGHT: o_gray_weight <= {o_gray_weight[15:0], code};
          T_ANA:  o_analog_setup <= {o_analog_setup[15:0], code};
          T_NVCT: begin
            o_nv_control     <= 1'b1;
            o_nv_control_arg <= code;
          end
          default: o_power_ctrl <= o_power_ctrl;
        endcase
      end
    end
  end

  // =====================================================================
  // Status read drive
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_reg <= `RST_STATUS;
      o_data     <= `RST_STATUS;
      o_data_oe  <= 1'b0;
    end else begin
      status_reg <= {o_bank_one, o_rmw_active, o_osc_run, o_dither_on,
                     o_nv_control, (remain_reg != 5'h00), o_nv_status_sel};
      o_data     <= status_reg;
      o_data_oe  <= rd_active && !rs;
    end
  end

endmodule

`default_nettype wire

// *** pkg/lcd_cmd_map.vh ***
// Command codes, parameter counts and reset values of the command decoder
// Assumes inclusion by bare name from design files
`ifndef LCD_CMD_MAP_VH
`define LCD_CMD_MAP_VH

// =====================================================================
// Bank select codes
`define BANK_ZERO_SEL        8'h30
`define BANK_ONE_SEL         8'h31
// =====================================================================
// Bank zero codes
`define C0_RMW_BEGIN         8'hE0
`define C0_RMW_END           8'hEE
`define C0_AREA_SCROLL       8'hAA
`define C0_SCROLL_LINE       8'hAB
`define C0_OSC_RUN           8'hD1
`define C0_OSC_STOP          8'hD2
`define C0_POWER_CTRL        8'h20
`define C0_CONTRAST_LOAD     8'h81
`define C0_CONTRAST_UP       8'hD6
`define C0_CONTRAST_DOWN     8'hD7
`define C0_RESERVED          8'h82
`define C0_NV_STAT_ONE       8'h7C
`define C0_NV_STAT_TWO       8'h7D
`define C0_NOP               8'h25
`define C0_NV_INIT_CODE      8'h07
// =====================================================================
// Bank one codes
`define C1_GRAY_FRAME_ONE    8'h20
`define C1_GRAY_FRAME_TWO    8'h21
`define C1_GRAY_WEIGHT       8'h22
`define C1_ANALOG_SETUP      8'h32
`define C1_DITHER_OFF        8'h34
`define C1_DITHER_ON         8'h35
`define C1_NV_CTRL_ENTER     8'hCD
`define C1_NV_CTRL_CANCEL    8'hCC
`define C1_NV_MEM_WRITE      8'hFC
`define C1_NV_MEM_READ       8'hFD
// =====================================================================
// Parameter byte counts
`define N_AREA_SCROLL        5'h04
`define N_SCROLL_LINE        5'h01
`define N_POWER_CTRL         5'h01
`define N_CONTRAST_LOAD      5'h02
`define N_NV_INIT_CODE       5'h01
`define N_GRAY_TABLE         5'h10
`define N_GRAY_WEIGHT        5'h03
`define N_ANALOG_SETUP       5'h03
`define N_NV_CTRL_ENTER      5'h01
// =====================================================================
// Reset values and contrast limit
`define RST_CONTRAST         6'h00
`define RST_BYTE             8'h00
`define RST_STATUS           8'h00
`define CONTRAST_MAX         6'h3F

`endif

// *** hdl/lcd_bus_front.v ***
// Host bus front end: synchronises strobes and yields access pulses
// Assumes asynchronous host pins and one 200 MHz system clock
`timescale 1ns/1ps
`default_nettype none

module lcd_bus_front (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_mode_enable,
  input  wire        i_cs_n,
  input  wire        i_wr_n,
  input  wire        i_rd_n,
  input  wire        i_rs,
  input  wire [15:0] i_data,
  output reg         o_write_pulse,
  output reg         o_read_active,
  output reg         o_rs,
  output reg  [15:0] o_data
);

  // =====================================================================
  // Two-stage synchronisers
  reg  [3:0]  meta_reg;
  reg  [3:0]  sync_reg;
  reg  [16:0] dmeta_reg;
  reg  [16:0] dsync_reg;
  reg         wr_act_reg;
  wire        wr_act;
  wire        rd_act;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg  <= 4'hF;
      sync_reg  <= 4'hF;
      dmeta_reg <= 17'h0_0000;
      dsync_reg <= 17'h0_0000;
    end else begin
      meta_reg  <= {i_mode_enable, i_cs_n, i_wr_n, i_rd_n};
      sync_reg  <= meta_reg;
      dmeta_reg <= {i_rs, i_data};
      dsync_reg <= dmeta_reg;
    end
  end

  // =====================================================================
  // Qualification by chip select
  // Enable mode: rd_n is read/write level, wr_n is enable (high = active)
  assign wr_act = sync_reg[3] ? (!sync_reg[2] && sync_reg[1] && !sync_reg[0])
                              : (!sync_reg[2] && !sync_reg[1]);
  assign rd_act = sync_reg[3] ? (!sync_reg[2] && sync_reg[1] && sync_reg[0])
                              : (!sync_reg[2] && !sync_reg[0]);

  // Data latched on the end of the strobe, as a parallel host expects
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_act_reg    <= 1'b0;
      o_write_pulse <= 1'b0;
      o_read_active <= 1'b0;
      o_rs          <= 1'b0;
      o_data        <= 16'h0000;
    end else begin
      wr_act_reg    <= wr_act;
      o_write_pulse <= wr_act_reg && !wr_act;
      o_read_active <= rd_act;
      // Select follows reads too, so a status read never sees a stale one
      if (wr_act || rd_act)
        o_rs <= dsync_reg[16];
      if (wr_act)
        o_data <= dsync_reg[15:0];
    end
  end

endmodule

`default_nettype wire

// *** test/lcd_command_decoder_properties.sv ***
// Port assertions for the command decoder
// Assumes bind into lcd_command_decoder, host strobes held 3+ clocks
`timescale 1ns/1ps
`default_nettype none
module lcd_command_decoder_properties (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_mode_enable,
  input wire logic       i_cs_n,
  input wire logic       i_wr_n,
  input wire logic       i_rd_n,
  input wire logic       i_register_select,
  input wire logic       o_data_oe,
  input wire logic       o_bank_one,
  input wire logic       o_osc_run,
  input wire logic [5:0] o_contrast_level,
  input wire logic       o_nv_write_start,
  input wire logic       o_nv_read_start,
  input wire logic [1:0] o_nv_status_sel,
  input wire logic       o_gray_write,
  input wire logic [3:0] o_gray_index,
  input wire logic       o_upper_byte_err
);
  // ===================================================================
  // Cycles since an access was seen; saturates so it never wraps
  logic [3:0] wcnt_reg;
  logic [3:0] rcnt_reg;
  logic [3:0] gidx_reg;
  wire        wr_seen = !i_cs_n &&
                        (i_mode_enable ? (i_wr_n && !i_rd_n) : !i_wr_n);
  wire        rd_seen = !i_cs_n && !i_register_select &&
                        (i_mode_enable ? (i_wr_n && i_rd_n) : !i_rd_n);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wcnt_reg <= 4'hF;
      rcnt_reg <= 4'hF;
      gidx_reg <= 4'hF;
    end else begin
      wcnt_reg <= wr_seen ? 4'h0 : wcnt_reg + {3'h0, wcnt_reg != 4'hF};
      rcnt_reg <= rd_seen ? 4'h0 : rcnt_reg + {3'h0, rcnt_reg != 4'hF};
      gidx_reg <= o_gray_write ? o_gray_index : gidx_reg;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ===================================================================
  // Sequences and assertions
  sequence s_wr_done;
    wcnt_reg >= 4'h2 && wcnt_reg <= 4'h8;
  endsequence
  sequence s_read_held;
    (rcnt_reg == 4'h0) [*5];
  endsequence
  a_write_pulse_single: assert property (o_nv_write_start
    |=> !o_nv_write_start)
    else $error("nv write start longer than one cycle");
  a_read_pulse_single: assert property (o_nv_read_start
    |=> !o_nv_read_start)
    else $error("nv read start longer than one cycle");
  a_nv_start_cause: assert property (o_nv_write_start
    || o_nv_read_start |-> s_wr_done ##0 o_bank_one)
    else $error("nv start without command");
  a_gray_after_write: assert property (o_gray_write
    |-> s_wr_done ##0 o_bank_one)
    else $error("gray write without parameter write");
  a_gray_index_step: assert property (o_gray_write
    && o_gray_index != 4'h0 |-> o_gray_index == gidx_reg + 4'h1)
    else $error("gray index skipped");
  a_setting_cause: assert property ($changed(o_osc_run)
    || $changed(o_bank_one) || $changed(o_contrast_level) |-> s_wr_done)
    else $error("setting changed without selected write");
  a_upper_err_cause: assert property ($changed(o_upper_byte_err)
    |-> s_wr_done)
    else $error("upper byte flag changed without write");
  a_status_sel_cause: assert property ($changed(o_nv_status_sel)
    |-> s_wr_done ##0 !o_bank_one)
    else $error("status select changed wrongly");
  a_oe_follows_read: assert property (s_read_held |-> o_data_oe)
    else $error("status not driven during read");
  a_oe_needs_read: assert property ($rose(o_data_oe)
    |-> rcnt_reg <= 4'h4)
    else $error("data driven without read");
  a_oe_released: assert property (rcnt_reg == 4'h8 |-> !o_data_oe)
    else $error("data still driven after read");
endmodule
bind lcd_command_decoder lcd_command_decoder_properties u_props (
  .i_clk, .i_rst_n, .i_mode_enable, .i_cs_n, .i_wr_n, .i_rd_n,
  .i_register_select, .o_data_oe, .o_bank_one, .o_osc_run,
  .o_contrast_level, .o_nv_write_start, .o_nv_read_start,
  .o_nv_status_sel, .o_gray_write, .o_gray_index, .o_upper_byte_err
);
`default_nettype wire

// *** test/lcd_host_model.sv ***
// Host processor model driving the decoder's parallel bus
// Assumes one free-running clock; all pin changes at the falling edge
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_mode_enable,
  input  wire logic [7:0]  i_status,
  input  wire logic        i_status_oe,
  output logic             o_cs_n,
  output logic             o_wr_n,
  output logic             o_rd_n,
  output logic             o_register_select,
  output logic [15:0]      o_data
);
  logic [7:0] last_status;
  logic       last_oe;
  initial begin
    o_cs_n = 1'b1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_register_select = 1'b1;
    o_data = 16'hA5A5;
  end
  // ===================================================================
  // One access, none for a command with low byte 82; sel low keeps chip select off to probe qualification
  task automatic access(input logic rs, input logic rd, input logic sel,
                        input logic [15:0] d);
    if (!rs && !rd && d[7:0] == 8'h82)
      return;
    @(negedge i_clk);
    o_cs_n = !sel;
    o_register_select = rs;
    o_data = rd ? ~o_data : d;
    // Enable mode: write strobe pin is the enable, high while active
    o_wr_n = i_mode_enable ? 1'b1 : rd;
    o_rd_n = i_mode_enable ? rd : !rd;
    repeat (6) @(negedge i_clk);
    last_status = i_status;
    last_oe = i_status_oe;
    o_wr_n = !i_mode_enable;
    o_rd_n = 1'b1;
    @(negedge i_clk);
    o_cs_n = 1'b1;
    // Released bus must not keep showing the old value
    o_data = ~o_data;
    repeat (5) @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

// *** test/lcd_command_decoder_tb.sv ***
// Self-checking bench for the command decoder
// Assumes the host model and the bound property checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h expected %h", $time, (a), (b)); end end
module lcd_command_decoder_tb;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_mode_enable = 1'b0;
  logic        i_cs_n, i_wr_n, i_rd_n, i_register_select;
  logic [15:0] i_data;
  logic        o_data_oe, o_bank_one, o_rmw_active, o_osc_run, o_dither_on;
  logic        o_nv_control, o_nv_write_start, o_nv_read_start;
  logic        o_gray_write, o_gray_frame, o_upper_byte_err;
  logic [1:0]  o_nv_status_sel;
  logic [3:0]  o_gray_index;
  logic [5:0]  o_contrast_level, up;
  logic [7:0]  o_data, o_power_ctrl, o_contrast_resist, o_scroll_first_line;
  logic [7:0]  o_nv_initial_code, o_nv_control_arg, o_gray_value, s;
  logic [23:0] o_gray_weight, o_analog_setup;
  logic [31:0] o_area_scroll;
  logic [7:0]  r[5];
  logic [7:0]  gexp[16];
  logic [5:0]  lv[3];
  logic        gframe;
  int          err_total, checks_done, gcount, wcount, rcount;
  always #2.5 i_clk = ~i_clk;
  lcd_command_decoder DUT (
    .i_clk, .i_rst_n, .i_mode_enable, .i_cs_n, .i_wr_n, .i_rd_n,
    .i_register_select, .i_data, .o_data, .o_data_oe, .o_bank_one,
    .o_rmw_active, .o_osc_run, .o_power_ctrl, .o_contrast_level,
    .o_contrast_resist, .o_scroll_first_line, .o_area_scroll,
    .o_nv_initial_code, .o_gray_weight, .o_analog_setup, .o_dither_on,
    .o_nv_control, .o_nv_control_arg, .o_nv_write_start, .o_nv_read_start,
    .o_nv_status_sel, .o_gray_write, .o_gray_frame, .o_gray_index,
    .o_gray_value, .o_upper_byte_err
  );
  lcd_host_model h (
    .i_clk, .i_mode_enable, .i_status(o_data), .i_status_oe(o_data_oe),
    .o_cs_n(i_cs_n), .o_wr_n(i_wr_n), .o_rd_n(i_rd_n),
    .o_register_select(i_register_select), .o_data(i_data)
  );
  // ===================================================================
  // Helpers
  task automatic cmd(input logic [7:0] c);
    h.access(1'b0, 1'b0, 1'b1, {8'h00, c});
  endtask
  task automatic par(input logic [7:0] b);
    h.access(1'b1, 1'b0, 1'b1, {8'h00, b});
  endtask
  function automatic logic [7:0] st(input logic o, input logic [1:0] sl);
    return {1'b0, 1'b0, o, 1'b0, 1'b0, 1'b0, sl};
  endfunction
  task automatic status(input logic [7:0] e);
    h.access(1'b0, 1'b1, 1'b1, 16'h0000);
    `CHK(h.last_oe, 1'b1)
    `CHK(h.last_status, e)
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Pulses are sampled mid-cycle, away from the launching edge
  always @(negedge i_clk) begin
    if (o_gray_write === 1'b1) begin
      `CHK(o_gray_value, gexp[o_gray_index])
      `CHK(o_gray_frame, gframe)
      gcount++;
    end
    wcount += int'(o_nv_write_start === 1'b1);
    rcount += int'(o_nv_read_start === 1'b1);
  end
  initial begin
    repeat (40000) @(posedge i_clk);
    err_total++;
    conclude();
  end
  // ===================================================================
  // Main sequence
  initial begin
    void'($urandom(32'h781c16d5));
    foreach (r[i]) r[i] = 8'($urandom);
    repeat (20) @(posedge i_clk);
    @(negedge i_clk) i_rst_n = 1'b1;
    `CHK(o_area_scroll, 32'h0000_0000)
    cmd(8'hD1);
    `CHK(o_osc_run, 1'b1)
    status(st(1'b1, 2'h0));
    cmd(8'hE0);
    cmd(8'h25);
    `CHK(o_rmw_active, 1'b1)
    `CHK(o_osc_run, 1'b1)
    cmd(8'hEE);
    `CHK(o_rmw_active, 1'b0)
    cmd(8'hD2);
    `CHK(o_osc_run, 1'b0)
    cmd(8'hAB);
    par(r[0]);
    par(r[1]);
    `CHK(o_scroll_first_line, r[0])
    cmd(8'hAA);
    for (int i = 0; i < 4; i++) par(r[i]);
    `CHK(o_area_scroll, {r[0], r[1], r[2], r[3]})
    cmd(8'h20);
    par(r[4]);
    `CHK(o_power_ctrl, r[4])
    status(st(1'b0, 2'h0));
    lv = '{r[0][5:0], 6'h3F, 6'h00};
    foreach (lv[k]) begin
      cmd(8'h81);
      par({2'b00, lv[k]});
      par(r[1]);
      `CHK(o_contrast_resist, r[1])
      cmd(8'hD6);
      up = (lv[k] == 6'h3F) ? 6'h3F : lv[k] + 6'h01;
      `CHK(o_contrast_level, up)
      cmd(8'hD7);
      `CHK(o_contrast_level, up - 6'h01)
    end
    cmd(8'hD7);
    `CHK(o_contrast_level, 6'h00)
    cmd(8'h07);
    par(r[2]);
    `CHK(o_nv_initial_code, r[2])
    cmd(8'h7C);
    `CHK(o_nv_status_sel, 2'h1)
    cmd(8'h7D);
    status(st(1'b0, 2'h2));
    cmd(8'h31);
    `CHK(o_bank_one, 1'b1)
    for (int f = 0; f < 2; f++) begin
      gframe = f[0];
      gcount = 0;
      cmd(8'h20 + 8'(f));
      for (int j = 0; j < 16; j++) begin
        gexp[j] = 8'($urandom);
        par(gexp[j]);
      end
      `CHK(gcount, 16)
    end
    `CHK(o_power_ctrl, r[4])
    cmd(8'h22);
    for (int i = 0; i < 3; i++) par(r[i]);
    cmd(8'h32);
    for (int i = 1; i < 4; i++) par(r[i]);
    `CHK(o_gray_weight, {r[0], r[1], r[2]})
    `CHK(o_analog_setup, {r[1], r[2], r[3]})
    cmd(8'h35);
    `CHK(o_dither_on, 1'b1)
    cmd(8'h34);
    `CHK(o_dither_on, 1'b0)
    cmd(8'hCD);
    par(r[3]);
    `CHK({o_nv_control, o_nv_control_arg}, {1'b1, r[3]})
    cmd(8'hCC);
    `CHK(o_nv_control, 1'b0)
    cmd(8'hFC);
    cmd(8'hFD);
    `CHK({wcount, rcount}, {32'd1, 32'd1})
    cmd(8'h30);
    `CHK(o_bank_one, 1'b0)
    h.access(1'b0, 1'b0, 1'b0, 16'h00D1);
    `CHK(o_osc_run, 1'b0)
    h.access(1'b0, 1'b0, 1'b1, 16'h5A25);
    `CHK(o_upper_byte_err, 1'b1)
    cmd(8'h25);
    `CHK(o_upper_byte_err, 1'b0)
    @(negedge i_clk) i_mode_enable = 1'b1;
    cmd(8'hD1);
    `CHK(o_osc_run, 1'b1)
    h.access(1'b0, 1'b0, 1'b0, 16'h00D2);
    `CHK(o_osc_run, 1'b1)
    status(st(1'b1, 2'h2));
    conclude();
  end
endmodule
`default_nettype wire
